/* File: hdl/trig_seq_pkg.sv */
`default_nettype none
package trig_seq_pkg;
    // ------------------------------------------------------------
    // Register map, word offsets as byte addresses
    // ------------------------------------------------------------
    localparam logic [5:0] ctrl_off = 6'h00;
    localparam logic [5:0] status_off = 6'h04;
    localparam logic [5:0] adjust_off = 6'h08;
    localparam logic [5:0] literal_off = 6'h0c;
    localparam logic [5:0] step_timer_off = 6'h10;
    localparam logic [5:0] loop_counter_off = 6'h14;
    localparam logic [5:0] step_delay_off = 6'h18;
    localparam logic [5:0] adc_select_off = 6'h1c;
    localparam logic [5:0] command_off = 6'h20;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int enable_bit = 0;
    localparam int start_bit = 1;
    localparam int mode_lsb = 2;
    localparam logic [15:0] reset_value = 16'h0000;
    // ------------------------------------------------------------
    // Commands, written to command_off bits 3:0
    // ------------------------------------------------------------
    localparam logic [3:0] cmd_wait_high = 4'h1;
    localparam logic [3:0] cmd_wait_low = 4'h2;
    localparam logic [3:0] cmd_ctrl_literal = 4'h3;
    localparam logic [3:0] cmd_add = 4'h4;
    localparam logic [3:0] cmd_ctrl_step = 4'h5;
    // Add target in command bits 5:4
    localparam logic [1:0] tgt_timer = 2'h0;
    localparam logic [1:0] tgt_loop = 2'h1;
    localparam logic [1:0] tgt_delay = 2'h2;
    localparam logic [1:0] tgt_literal = 2'h3;
    // Wait mode codes
    localparam logic [1:0] mode_edge_delay = 2'h0;
    localparam logic [1:0] mode_edge_nodelay = 2'h1;
    localparam logic [1:0] mode_level_delay = 2'h2;
    localparam logic [1:0] mode_level_nodelay = 2'h3;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_wait = 2'b01,
        st_delay = 2'b10
    } seq_state_t;
endpackage
`default_nettype wire

/* File: hdl/pin_sync.sv */
`default_nettype none
module pin_sync (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic [2:0] sh;
        logic lvl;
    } sync_t;
    sync_t s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.sh = {s_r.sh[1:0], pin};
        // Only stages two and three are compared, stage one stays private
        if (s_r.sh[1] == s_r.sh[2]) begin
            s_nxt.lvl = s_r.sh[2];
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign level = s_r.lvl;
endmodule
`default_nettype wire

/* File: hdl/trig_seq.sv */
// Overview of operation
// - Mode 11 level detect, no step delay; mode 10 level detect then delay.
// - Mode 01 edge detect, no step delay; mode 00 edge detect then delay.
// - Wait mode matters only to wait-high and wait-low commands.
// - Add command sums adjust value into chosen limit or literal register.
// - Control literal command copies literal value to ADC channel-0 select.
// - Adjust and literal are read-only while enable and start both set.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`default_nettype none
module trig_seq
    import trig_seq_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic trigger_in,
    output logic [15:0] adc_channel0_select,
    output logic busy
);
    import trig_seq_pkg::*;
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic sequencer_enable;
        logic sequencer_start;
        logic [1:0] trigger_wait_mode;
        logic [15:0] adjust_value;
        logic [15:0] literal_zero_value;
        logic [15:0] step_timer_limit;
        logic [15:0] loop_counter_limit;
        logic [15:0] step_delay_limit;
        logic [15:0] adc_sel;
        seq_state_t state;
        logic wait_high;
        logic trig_prev;
        logic [15:0] delay_cnt;
        logic [31:0] rdata;
        logic waitreq;
        logic busy;
    } regs_t;
    regs_t r_r, r_nxt;
    logic trig;
    logic running;
    logic [15:0] wdata;
    logic hit;
    logic take;
    logic cmd_ok;
    logic at_level;
    logic [3:0] cmd_code;
    logic [1:0] cmd_tgt;
    // ------------------------------------------------------------
    // Trigger input
    // ------------------------------------------------------------
    // Pin is asynchronous; its level lags the pin by four edges
    pin_sync u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .pin(trigger_in),
        .level(trig)
    );
    assign running = r_r.sequencer_enable & r_r.sequencer_start;
    assign wdata = avs_writedata[15:0];
    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // Taken only while waitrequest is high, so a held request acts once
    assign take = (avs_read || avs_write) && r_r.waitreq;
    // Commands start only from idle; a running wait is never restarted
    assign cmd_ok = running && (r_r.state == st_idle);
    assign cmd_code = wdata[3:0];
    assign cmd_tgt = wdata[5:4];
    assign at_level = (trig == r_r.wait_high);
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_nxt = r_r;
        r_nxt.waitreq = 1'b1;
        r_nxt.trig_prev = trig;
        hit = 1'b0;
        // ------------------------------------------------------------
        // Register bus
        // ------------------------------------------------------------
        // One-cycle waitrequest: answer at the second edge of a request
        if (take) begin
            r_nxt.waitreq = 1'b0;
            r_nxt.rdata = '0;
            if (avs_read) begin
                unique case (avs_address)
                    ctrl_off: r_nxt.rdata = {28'h0000000,
                        r_r.trigger_wait_mode, r_r.sequencer_start,
                        r_r.sequencer_enable};
                    status_off: r_nxt.rdata = {30'h00000000,
                        r_r.state};
                    adjust_off: r_nxt.rdata = {16'h0000, r_r.adjust_value};
                    literal_off: r_nxt.rdata = {16'h0000,
                        r_r.literal_zero_value};
                    step_timer_off: r_nxt.rdata = {16'h0000,
                        r_r.step_timer_limit};
                    loop_counter_off: r_nxt.rdata = {16'h0000,
                        r_r.loop_counter_limit};
                    step_delay_off: r_nxt.rdata = {16'h0000,
                        r_r.step_delay_limit};
                    adc_select_off: r_nxt.rdata = {16'h0000, r_r.adc_sel};
                    // Command register is write only and reads as zero
                    default: r_nxt.rdata = '0;
                endcase
            end else if (avs_byteenable[0]) begin
                // Registers are at most 16 bits wide, lane zero alone gates a write
                unique case (avs_address)
                    ctrl_off: begin
                        r_nxt.sequencer_enable = wdata[enable_bit];
                        r_nxt.sequencer_start = wdata[start_bit];
                        r_nxt.trigger_wait_mode = wdata[mode_lsb +: 2];
                    end
                    adjust_off: if (!running) begin
                        r_nxt.adjust_value = wdata;
                    end
                    literal_off: if (!running) begin
                        r_nxt.literal_zero_value = wdata;
                    end
                    step_timer_off: r_nxt.step_timer_limit = wdata;
                    loop_counter_off: r_nxt.loop_counter_limit = wdata;
                    step_delay_off: r_nxt.step_delay_limit = wdata;
                    command_off: if (cmd_ok) begin
                        unique case (cmd_code)
                            cmd_wait_high, cmd_wait_low: begin
                                r_nxt.state = st_wait;
                                r_nxt.wait_high = (cmd_code == cmd_wait_high);
                            end
                            cmd_add: begin
                                // Sum wraps at 16 bits, the carry is lost
                                unique case (cmd_tgt)
                                    tgt_timer: r_nxt.step_timer_limit =
                                        r_r.step_timer_limit +
                                        r_r.adjust_value;
                                    tgt_loop: r_nxt.loop_counter_limit =
                                        r_r.loop_counter_limit +
                                        r_r.adjust_value;
                                    tgt_delay: r_nxt.step_delay_limit =
                                        r_r.step_delay_limit +
                                        r_r.adjust_value;
                                    tgt_literal: r_nxt.literal_zero_value =
                                        r_r.literal_zero_value +
                                        r_r.adjust_value;
                                endcase
                            end
                            cmd_ctrl_literal: begin
                                r_nxt.adc_sel = r_r.literal_zero_value;
                            end
                            // Wait mode ignored by all other commands
                            default: r_nxt.state = st_idle;
                        endcase
                    end
                    default: ;
                endcase
            end
        end
        // ------------------------------------------------------------
        // Wait and step delay
        // ------------------------------------------------------------
        unique case (r_r.state)
            st_idle: ;
            st_wait: begin
                if (r_r.trigger_wait_mode[1]) begin
                    hit = at_level;
                end else begin
                    hit = at_level &&
                        (r_r.trig_prev != r_r.wait_high);
                end
                if (hit) begin
                    // Odd codes skip the delay regardless of control step
                    if (r_r.trigger_wait_mode[0] ||
                        r_r.step_delay_limit == 16'h0000) begin
                        r_nxt.state = st_idle;
                    end else begin
                        r_nxt.state = st_delay;
                        r_nxt.delay_cnt = r_r.step_delay_limit;
                    end
                end
            end
            st_delay: begin
                // Holds for the full limit, exit edge included
                r_nxt.delay_cnt = r_r.delay_cnt - 16'h0001;
                if (r_r.delay_cnt == 16'h0001) begin
                    r_nxt.state = st_idle;
                end
            end
            default: r_nxt.state = st_idle;
        endcase
        // Dropping enable or start aborts a wait or a delay
        if (!running) begin
            r_nxt.state = st_idle;
        end
        r_nxt.busy = (r_nxt.state != st_idle);
    end
    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            r_r <= '0;
            // Waitrequest idles high so a request is taken at the first edge after reset
            r_r.waitreq <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata = r_r.rdata;
    assign avs_waitrequest = r_r.waitreq;
    assign adc_channel0_select = r_r.adc_sel;
    assign busy = r_r.busy;
endmodule
`default_nettype wire

/* File: testbench/trig_seq_checker.sv */
`default_nettype none
module trig_seq_checker
    import trig_seq_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [15:0] adc_channel0_select,
    input wire logic busy
);
    // ----
    // Bus and output timing
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest;
    endsequence
    AST_ANSWER: assert property (s_req |=> s_ans)
        else $error("no answer after one wait cycle");
    AST_ONE_CYCLE: assert property (s_ans |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    AST_IDLE_HIGH: assert property (!(avs_read || avs_write) |=>
        avs_waitrequest) else $error("answer without request");
    AST_UPPER_ZERO: assert property (s_ans ##0 avs_read |->
        avs_readdata[31:16] == 16'h0000) else $error("upper half not zero");
    AST_UNMAPPED: assert property (s_ans ##0 avs_read &&
        avs_address > command_off |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_STATE_CODE: assert property (s_ans ##0 avs_read &&
        avs_address == status_off |-> avs_readdata[1:0] != 2'h3)
        else $error("bad state code");
    AST_ADC_CAUSE: assert property ($changed(adc_channel0_select) |->
        $past(avs_write && avs_address == command_off))
        else $error("select changed without command");
    AST_BUSY_CAUSE: assert property ($rose(busy) |->
        $past(avs_write && avs_address == command_off))
        else $error("busy without command");
endmodule
bind trig_seq trig_seq_checker chk_i (.mclk, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .adc_channel0_select, .busy);
`default_nettype wire

/* File: testbench/tb_trig_seq.sv */
`default_nettype none
module tb_trig_seq;
    timeunit 1ns;
    timeprecision 1ps;
    import trig_seq_pkg::*;
    logic mclk, resetn, avs_read, avs_write, trigger_in, avs_waitrequest;
    logic busy;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] adc_channel0_select, adj, lit, old;
    logic [5:0] lim_addr;
    int num_errors = 0, compares = 0, seed = 33, n;
    trig_seq uut (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .trigger_in(trigger_in), .adc_channel0_select(adc_channel0_select),
        .busy(busy));
    // ----
    // Tasks and expectations
    // ----
    function automatic logic [1:0] exp_state(input logic [1:0] m);
        return m[1] ? (m[0] ? 2'h0 : 2'h2) : 2'h1;
    endfunction
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        q = avs_readdata;
        if (k == 50) begin
            num_errors++;
            end_of_test();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        {resetn, avs_read, avs_write, trigger_in} = 4'h0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        bus(1'b0, adjust_off, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, literal_off, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 6'h3c, 32'h0);
        chk(q, 32'h0);
        chk(32'(adc_channel0_select), 32'h0);
        $display("test reset done");
        adj = 16'($random(seed));
        lit = 16'($random(seed));
        bus(1'b1, adjust_off, 32'(adj));
        bus(1'b1, literal_off, 32'(lit));
        bus(1'b1, ctrl_off, 32'h0f);
        bus(1'b1, adjust_off, 32'(~adj));
        bus(1'b0, adjust_off, 32'h0);
        chk(q, 32'(adj));
        bus(1'b1, literal_off, 32'(~lit));
        bus(1'b0, literal_off, 32'h0);
        chk(q, 32'(lit));
        for (int t = 0; t < 4; t++) begin
            lim_addr = (t == 3) ? literal_off : 6'(step_timer_off + 4 * t);
            bus(1'b0, lim_addr, 32'h0);
            old = q[15:0];
            bus(1'b1, command_off, 32'({t[1:0], cmd_add}));
            bus(1'b0, lim_addr, 32'h0);
            chk(q, 32'(16'(old + adj)));
            if (t == 3) lit = 16'(old + adj);
        end
        bus(1'b1, command_off, 32'(cmd_ctrl_literal));
        @(posedge mclk);
        chk(32'(adc_channel0_select), 32'(lit));
        bus(1'b0, adc_select_off, 32'h0);
        chk(q, 32'(lit));
        $display("test add and copy done");
        bus(1'b1, ctrl_off, 32'h0);
        bus(1'b1, step_delay_off, 32'd20);
        for (int m = 0; m < 4; m++) begin
            trigger_in <= 1'b1;
            // Level settles first so edge modes see no edge at the start
            repeat (8) @(posedge mclk);
            bus(1'b1, ctrl_off, 32'({m[1:0], 2'h3}));
            bus(1'b1, command_off, 32'(cmd_wait_high));
            repeat (8) @(posedge mclk);
            chk(32'(busy), 32'(exp_state(2'(m)) != 2'h0));
            bus(1'b0, status_off, 32'h0);
            chk(32'(q[1:0]), 32'(exp_state(2'(m))));
            if (m < 2) begin
                trigger_in <= 1'b0;
                repeat (8) @(posedge mclk);
                trigger_in <= 1'b1;
                repeat (8) @(posedge mclk);
                bus(1'b0, status_off, 32'h0);
                chk(32'(q[1:0]), (m == 0) ? 32'h2 : 32'h0);
            end
            n = 0;
            while (busy !== 1'b0 && n < 200) begin
                @(posedge mclk);
                n++;
            end
            if (n == 200) begin
                num_errors++;
                end_of_test();
            end
            bus(1'b1, ctrl_off, 32'h0);
        end
        $display("test wait modes done");
        bus(1'b1, ctrl_off, 32'({mode_edge_nodelay, 2'h3}));
        bus(1'b1, command_off, 32'(cmd_wait_low));
        repeat (8) @(posedge mclk);
        chk(32'(busy), 32'h1);
        trigger_in <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(32'(busy), 32'h0);
        bus(1'b1, ctrl_off, 32'({mode_level_delay, 2'h3}));
        bus(1'b1, command_off, 32'(cmd_wait_low));
        bus(1'b0, status_off, 32'h0);
        chk(32'(q[1:0]), 32'h2);
        $display("test wait low done");
        end_of_test();
    end
endmodule
`default_nettype wire
